// ===== design/meter_config_io_ram.v
`timescale 1ns/1ps
// Contract
// (R1) Write-only bits read back as zero
// (R2) Distinct reset and wake values applied; code loads identical reset and wake values
// (R3) Converter enable powers converter and reference
// (R4) Battery measure loads battery, alternate cycles
// (R5) Engine start address is 1024 times base
// (R6) Software sets base before enabling engine
// (R7) Chop select decode: toggle, positive, reversed
// (R8) Chop polarity updates on frame sync rise
// (R9) Auto mode skips toggle at interval end
// (R10) Test clock select drives test pin
// (R11) Comparator status reads live output
// (R12) Route fields connect pins to resources
// (R13) Shared resources OR their routed pins
// (R14) Codes 000 none, 001 reserved, 010 timer0
// (R15) Codes 011 to 111 timer1 and interrupts
// (R16) Unused bits hold nothing, read zero
// (R17) Writes take effect the following cycle
module meter_config_io_ram (
	input wire clk,
	input wire rst,
	input wire wake,
	input wire [15:0] addr,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] wr_data,
	output reg [7:0] rd_data,
	input wire mux_frame_sync,
	input wire accumulation_interval,
	input wire alternate_mux_cycle,
	input wire comparator_out,
	input wire filter_clock,
	input wire lcd_segment_nineteen,
	input wire pushbutton_input,
	input wire optical_receive,
	input wire [6:0] dio_pins,
	output wire converter_power,
	output wire battery_load,
	output wire battery_to_converter,
	output wire engine_run,
	output wire [15:0] engine_start_addr,
	output wire chop_polarity,
	output wire test_clock_pin,
	output reg timer_zero_input,
	output reg timer_one_input,
	output reg high_priority_irq,
	output reg low_priority_irq
);
`include "meter_config_regs.vh"
	// ----------------------------------------
	// Configuration storage
	// ----------------------------------------
	reg engine_run_ff;
	reg [1:0] chop_sel_ff;
	reg [1:0] test_clock_select_ff;
	reg converter_ff;
	reg battery_load_measure_ff;
	reg [4:0] engine_code_base_ff;
	reg [26:0] route_ff;
	reg chop_pol_ff;
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [11:0] sync1_ff;
	reg [11:0] sync2_ff;
	reg frame_prev_ff;
	wire [11:0] raw_in;
	assign raw_in = {comparator_out, mux_frame_sync, accumulation_interval, dio_pins, optical_receive,
		pushbutton_input};
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 12'h000;
			sync2_ff <= 12'h000;
			frame_prev_ff <= 1'b0;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			frame_prev_ff <= sync2_ff[10];
		end
	end
	wire comp_s;
	wire frame_s;
	wire accum_s;
	wire [8:0] pins_s;
	wire frame_rise;
	assign comp_s = sync2_ff[11];
	assign frame_s = sync2_ff[10];
	assign accum_s = sync2_ff[9];
	assign pins_s = sync2_ff[8:0];
	assign frame_rise = frame_s & ~frame_prev_ff; // (R8)
	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Wake outranks a write; the status location has no write decode at all
	wire wr_take;
	wire hit_engine_run;
	wire hit_chop;
	wire hit_config0;
	wire hit_config1;
	wire hit_route_a;
	wire hit_route_b;
	wire hit_route_c;
	wire hit_route_d;
	wire hit_route_e;
	wire hit_lcdx;
	wire hit_code_base;
	assign wr_take = wr_en & ~wake; // (R17)
	assign hit_engine_run = wr_take & (addr == `ADDR_ENGINE_RUN);
	assign hit_chop = wr_take & (addr == `ADDR_CHOP);
	assign hit_config0 = wr_take & (addr == `ADDR_CONFIG0);
	assign hit_config1 = wr_take & (addr == `ADDR_CONFIG1);
	assign hit_route_a = wr_take & (addr == `ADDR_ROUTE_A);
	assign hit_route_b = wr_take & (addr == `ADDR_ROUTE_B);
	assign hit_route_c = wr_take & (addr == `ADDR_ROUTE_C);
	assign hit_route_d = wr_take & (addr == `ADDR_ROUTE_D);
	assign hit_route_e = wr_take & (addr == `ADDR_ROUTE_E);
	assign hit_lcdx = wr_take & (addr == `ADDR_LCDX);
	assign hit_code_base = wr_take & (addr == `ADDR_CODE_BASE);
	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			engine_run_ff <= 1'b0;
		end else if (wake) begin // (R2)
			engine_run_ff <= 1'b0;
		end else if (hit_engine_run) begin // (R17)
			engine_run_ff <= wr_data[`POS_ENGINE_RUN];
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			chop_sel_ff <= 2'h0; // (R7)
		end else if (wake) begin // (R2)
			chop_sel_ff <= 2'h0;
		end else if (hit_chop) begin // (R17)
			chop_sel_ff <= wr_data[`POS_CHOP +: 2];
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			test_clock_select_ff <= 2'h0;
		end else if (wake) begin // (R2)
			test_clock_select_ff <= 2'h0;
		end else if (hit_config0) begin // (R17)
			test_clock_select_ff <= wr_data[`POS_TEST_CLOCK +: 2];
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			converter_ff <= 1'b0;
		end else if (wake) begin // (R2)
			converter_ff <= 1'b0; // (R3)
		end else if (hit_config1) begin // (R17)
			converter_ff <= wr_data[`POS_CONVERTER];
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			engine_code_base_ff <= `RST_CODE_BASE; // (R5)
		end else if (wake) begin // (R2)
			engine_code_base_ff <= `WAKE_CODE_BASE; // (R5)
		end else if (hit_code_base) begin // (R17)
			engine_code_base_ff <= wr_data[`POS_CODE_BASE +: 5];
		end
	end
	// Battery measure has no wake value and keeps its state
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			battery_load_measure_ff <= 1'b0;
		end else if (hit_lcdx) begin // (R17)
			battery_load_measure_ff <= wr_data[`POS_BATTERY];
		end
	end
	// Route slot order: pushbutton, pin one, two, four to nine
	always @(posedge clk or posedge rst) begin
		if (rst) begin // (R2)
			route_ff <= 27'h000_0000; // (R14)
		end else if (wake) begin // (R2)
			route_ff <= 27'h000_0000; // (R14)
		end else begin
			if (hit_route_a) begin
				route_ff[2:0] <= wr_data[`POS_ROUTE_LO +: 3];
				route_ff[5:3] <= wr_data[`POS_ROUTE_HI +: 3];
			end
			if (hit_route_b) begin
				route_ff[8:6] <= wr_data[`POS_ROUTE_LO +: 3];
			end
			if (hit_route_c) begin
				route_ff[11:9] <= wr_data[`POS_ROUTE_LO +: 3];
				route_ff[14:12] <= wr_data[`POS_ROUTE_HI +: 3];
			end
			if (hit_route_d) begin
				route_ff[17:15] <= wr_data[`POS_ROUTE_LO +: 3];
				route_ff[20:18] <= wr_data[`POS_ROUTE_HI +: 3];
			end
			if (hit_route_e) begin
				route_ff[23:21] <= wr_data[`POS_ROUTE_LO +: 3];
				route_ff[26:24] <= wr_data[`POS_ROUTE_HI +: 3];
			end
		end
	end
	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Only listed fields drive bits; all others read as zero
	reg [7:0] nxt_rd_data;
	always @* begin
		nxt_rd_data = 8'h00; // (R16) (R1)
		case (addr)
			`ADDR_ENGINE_RUN: nxt_rd_data[`POS_ENGINE_RUN] = engine_run_ff;
			`ADDR_CHOP: nxt_rd_data[`POS_CHOP +: 2] = chop_sel_ff;
			`ADDR_COMP: nxt_rd_data[`POS_COMP] = comp_s; // (R11)
			`ADDR_CONFIG0: nxt_rd_data[`POS_TEST_CLOCK +: 2] = test_clock_select_ff;
			`ADDR_CONFIG1: nxt_rd_data[`POS_CONVERTER] = converter_ff;
			`ADDR_ROUTE_A: begin
				nxt_rd_data[`POS_ROUTE_LO +: 3] = route_ff[2:0];
				nxt_rd_data[`POS_ROUTE_HI +: 3] = route_ff[5:3];
			end
			`ADDR_ROUTE_B: nxt_rd_data[`POS_ROUTE_LO +: 3] = route_ff[8:6];
			`ADDR_ROUTE_C: begin
				nxt_rd_data[`POS_ROUTE_LO +: 3] = route_ff[11:9];
				nxt_rd_data[`POS_ROUTE_HI +: 3] = route_ff[14:12];
			end
			`ADDR_ROUTE_D: begin
				nxt_rd_data[`POS_ROUTE_LO +: 3] = route_ff[17:15];
				nxt_rd_data[`POS_ROUTE_HI +: 3] = route_ff[20:18];
			end
			`ADDR_ROUTE_E: begin
				nxt_rd_data[`POS_ROUTE_LO +: 3] = route_ff[23:21];
				nxt_rd_data[`POS_ROUTE_HI +: 3] = route_ff[26:24];
			end
			`ADDR_LCDX: nxt_rd_data[`POS_BATTERY] = battery_load_measure_ff;
			`ADDR_CODE_BASE: nxt_rd_data[`POS_CODE_BASE +: 5] = engine_code_base_ff;
			default: nxt_rd_data = 8'h00;
		endcase
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= nxt_rd_data;
		end
	end
	// ----------------------------------------
	// Bandgap chop polarity
	// ----------------------------------------
	reg nxt_chop_pol;
	always @* begin
		nxt_chop_pol = chop_pol_ff;
		if (frame_rise) begin // (R8)
			case (chop_sel_ff) // (R7)
				`CHOP_AUTO: nxt_chop_pol = accum_s ? chop_pol_ff : ~chop_pol_ff; // (R9)
				`CHOP_POS: nxt_chop_pol = 1'b0;
				`CHOP_REV: nxt_chop_pol = 1'b1;
				`CHOP_TOGGLE: nxt_chop_pol = ~chop_pol_ff;
				default: nxt_chop_pol = chop_pol_ff;
			endcase
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			chop_pol_ff <= 1'b0;
		end else begin
			chop_pol_ff <= nxt_chop_pol;
		end
	end
	assign chop_polarity = chop_pol_ff;
	// ----------------------------------------
	// Analog and engine controls
	// ----------------------------------------
	assign converter_power = converter_ff; // (R3)
	assign battery_load = battery_load_measure_ff; // (R4)
	assign battery_to_converter = battery_load_measure_ff & alternate_mux_cycle; // (R4)
	// Engine run left to software ordering against the code base
	assign engine_run = engine_run_ff; // (R6)
	// Largest base times the scale still fits in sixteen bits
	assign engine_start_addr = {11'h000, engine_code_base_ff} * `CODE_BASE_SCALE; // (R5)
	// Production test codes fall back to a quiet low pin
	assign test_clock_pin = (test_clock_select_ff == `CKSEL_SEGMENT) ? lcd_segment_nineteen : // (R10)
		(test_clock_select_ff == `CKSEL_FILTER) ? filter_clock : 1'b0;
	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	wire timer_zero_w;
	wire timer_one_w;
	wire hr_w;
	wire lr_w;
	wire hf_w;
	wire lf_w;
	pin_route_mux u_route (
		.route_codes(route_ff),
		.pin_levels(pins_s),
		.timer_zero_input(timer_zero_w),
		.timer_one_input(timer_one_w),
		.high_rise(hr_w),
		.low_rise(lr_w),
		.high_fall(hf_w),
		.low_fall(lf_w)
	);
	// ----------------------------------------
	// Interrupt edge detection
	// ----------------------------------------
	// Edge-sensitive routes become one-cycle interrupt pulses
	// Previous levels reset low, the idle level of an unrouted resource,
	// so no false falling edge follows reset
	reg hr_prev_ff;
	reg lr_prev_ff;
	reg hf_prev_ff;
	reg lf_prev_ff;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hr_prev_ff <= 1'b0;
			lr_prev_ff <= 1'b0;
			hf_prev_ff <= 1'b0;
			lf_prev_ff <= 1'b0;
		end else begin
			hr_prev_ff <= hr_w;
			lr_prev_ff <= lr_w;
			hf_prev_ff <= hf_w;
			lf_prev_ff <= lf_w;
		end
	end
	wire high_rise_pulse;
	wire low_rise_pulse;
	wire high_fall_pulse;
	wire low_fall_pulse;
	assign high_rise_pulse = hr_w & ~hr_prev_ff; // (R15)
	assign low_rise_pulse = lr_w & ~lr_prev_ff; // (R15)
	assign high_fall_pulse = ~hf_w & hf_prev_ff; // (R15)
	assign low_fall_pulse = ~lf_w & lf_prev_ff; // (R15)
	// ----------------------------------------
	// Registered resource outputs
	// ----------------------------------------
	// Pins ORed onto one resource share a single edge detector
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_zero_input <= 1'b0;
			timer_one_input <= 1'b0;
			high_priority_irq <= 1'b0;
			low_priority_irq <= 1'b0;
		end else begin
			timer_zero_input <= timer_zero_w; // (R12)
			timer_one_input <= timer_one_w; // (R15)
			high_priority_irq <= high_rise_pulse | high_fall_pulse; // (R15)
			low_priority_irq <= low_rise_pulse | low_fall_pulse; // (R15)
		end
	end
endmodule // meter_config_io_ram

// ===== design/meter_config_regs.vh
`ifndef METER_CONFIG_REGS_VH
`define METER_CONFIG_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_ENGINE_RUN 16'h2000
`define ADDR_CHOP 16'h2002
`define ADDR_COMP 16'h2003
`define ADDR_CONFIG0 16'h2004
`define ADDR_CONFIG1 16'h2005
`define ADDR_ROUTE_A 16'h2009
`define ADDR_ROUTE_B 16'h200a
`define ADDR_ROUTE_C 16'h200b
`define ADDR_ROUTE_D 16'h200c
`define ADDR_ROUTE_E 16'h200d
`define ADDR_LCDX 16'h2020
`define ADDR_CODE_BASE 16'h20a8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_ENGINE_RUN 4
`define POS_CHOP 4
`define POS_COMP 0
`define POS_TEST_CLOCK 4
`define POS_CONVERTER 3
`define POS_ROUTE_LO 0
`define POS_ROUTE_HI 4
`define POS_BATTERY 6
`define POS_CODE_BASE 0
// ----------------------------------------
// Reset and wake values
// ----------------------------------------
`define RST_CODE_BASE 5'h1f
`define WAKE_CODE_BASE 5'h1f
`define CODE_BASE_SCALE 16'h0400
// ----------------------------------------
// Routing and chop codes
// ----------------------------------------
`define ROUTE_NONE 3'h0
`define ROUTE_TIMER_ZERO 3'h2
`define ROUTE_TIMER_ONE 3'h3
`define ROUTE_HIGH_RISE 3'h4
`define ROUTE_LOW_RISE 3'h5
`define ROUTE_HIGH_FALL 3'h6
`define ROUTE_LOW_FALL 3'h7
`define CHOP_AUTO 2'h0
`define CHOP_POS 2'h1
`define CHOP_REV 2'h2
`define CHOP_TOGGLE 2'h3
`define CKSEL_SEGMENT 2'h0
`define CKSEL_FILTER 2'h1
`endif

// ===== design/pin_route_mux.v
`timescale 1ns/1ps
// ----------------------------------------
// Routes nine input pins onto shared resources
// ----------------------------------------
module pin_route_mux (
	input wire [26:0] route_codes,
	input wire [8:0] pin_levels,
	output reg timer_zero_input,
	output reg timer_one_input,
	output reg high_rise,
	output reg low_rise,
	output reg high_fall,
	output reg low_fall
);
`include "meter_config_regs.vh"
	integer i;
	reg [2:0] code;
	always @* begin
		code = 3'h0;
		timer_zero_input = 1'b0;
		timer_one_input = 1'b0;
		high_rise = 1'b0;
		low_rise = 1'b0;
		high_fall = 1'b0;
		low_fall = 1'b0;
		// Reserved code and none both contribute nothing
		for (i = 0; i < 9; i = i + 1) begin
			code = route_codes[i*3 +: 3];
			case (code) // (R12) (R14) (R15)
				`ROUTE_TIMER_ZERO: timer_zero_input = timer_zero_input | pin_levels[i]; // (R13)
				`ROUTE_TIMER_ONE: timer_one_input = timer_one_input | pin_levels[i]; // (R13)
				`ROUTE_HIGH_RISE: high_rise = high_rise | pin_levels[i]; // (R13)
				`ROUTE_LOW_RISE: low_rise = low_rise | pin_levels[i]; // (R13)
				`ROUTE_HIGH_FALL: high_fall = high_fall | pin_levels[i]; // (R13)
				`ROUTE_LOW_FALL: low_fall = low_fall | pin_levels[i]; // (R13)
				default: code = code;
			endcase
		end
	end
endmodule // pin_route_mux

// ===== test/frame_source.sv
`timescale 1ns/1ps
// ----------------------------------------
// Front-end frame timing: 16-cycle frames, interval ends every fourth
// ----------------------------------------
module frame_source (
	input wire clk,
	input wire rst,
	output reg mux_frame_sync,
	output reg accumulation_interval,
	output reg alternate_mux_cycle
);
reg [5:0] cnt_ff;
always @(posedge clk or posedge rst) begin
	if (rst) cnt_ff <= 6'h00;
	else cnt_ff <= cnt_ff + 6'h01;
end
// Interval level spans the frame rise it ends, so the sampled level is unambiguous
always @* begin
	mux_frame_sync = cnt_ff[3:0] < 4'h4;
	accumulation_interval = (cnt_ff[5:3] == 3'h7) || (cnt_ff[5:2] == 4'h0);
	alternate_mux_cycle = cnt_ff[4];
end
endmodule // frame_source

// ===== test/meter_config_io_ram_assertions.sv
`timescale 1ns/1ps
module meter_config_checker (
	input wire clk,
	input wire rst,
	input wire wake,
	input wire [15:0] addr,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] wr_data,
	input wire [7:0] rd_data,
	input wire alternate_mux_cycle,
	input wire filter_clock,
	input wire converter_power,
	input wire battery_load,
	input wire battery_to_converter,
	input wire engine_run,
	input wire [15:0] engine_start_addr,
	input wire test_clock_pin,
	input wire high_priority_irq
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire wr_ok = wr_en && !wake;
property p_conv; wr_ok && addr == 16'h2005 |=> converter_power == $past(wr_data[3]); endproperty
a_conv: assert property (p_conv) else $error("converter enable not written");
property p_run; wr_ok && addr == 16'h2000 |=> engine_run == $past(wr_data[4]); endproperty
a_run: assert property (p_run) else $error("engine enable not written");
property p_base; wr_ok && addr == 16'h20a8 |=> engine_start_addr == {1'b0, $past(wr_data[4:0]), 10'h000}; endproperty
a_base: assert property (p_base) else $error("engine start address wrong");
property p_bat; battery_to_converter == (battery_load && alternate_mux_cycle); endproperty
a_bat: assert property (p_bat) else $error("battery path wrong");
property p_tclk; wr_ok && addr == 16'h2004 && wr_data[5:4] == 2'h1 |=> test_clock_pin == filter_clock; endproperty
a_tclk: assert property (p_tclk) else $error("test pin not filter clock");
property p_wake; wake |=> engine_start_addr == 16'h7c00 && !converter_power && !engine_run; endproperty
a_wake: assert property (p_wake) else $error("wake values not loaded");
property p_hold; !rd_en |=> $stable(rd_data); endproperty
a_hold: assert property (p_hold) else $error("read data moved");
property p_unmap; rd_en && addr == 16'h2001 |=> rd_data == 8'h00; endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
property p_unused; rd_en && addr == 16'h2009 |=> !rd_data[7] && !rd_data[3]; endproperty
a_unused: assert property (p_unused) else $error("unused route bits set");
property p_irq; high_priority_irq |=> !high_priority_irq; endproperty
a_irq: assert property (p_irq) else $error("irq pulse too long");
endmodule // meter_config_checker
bind meter_config_io_ram meter_config_checker chk_i (.*);

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
reg clk, rst, wake, wr_en, rd_en, cmp, fck, seg, push, opt;
reg [15:0] addr;
reg [7:0] wr_data;
reg [6:0] dio;
wire [7:0] rd_data;
wire fs, acc, alt, cp, bl, btc, er, pol, tp, tmr_zero, tmr_one, hi, lo;
wire [15:0] esa;
integer mismatches, compares, i, j, nh, nl, nc;
frame_source fsrc (.clk(clk), .rst(rst), .mux_frame_sync(fs), .accumulation_interval(acc),
	.alternate_mux_cycle(alt));
meter_config_io_ram uut (.clk(clk), .rst(rst), .wake(wake), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
	.wr_data(wr_data), .rd_data(rd_data), .mux_frame_sync(fs), .accumulation_interval(acc),
	.alternate_mux_cycle(alt), .comparator_out(cmp), .filter_clock(fck), .lcd_segment_nineteen(seg),
	.pushbutton_input(push), .optical_receive(opt), .dio_pins(dio), .converter_power(cp), .battery_load(bl),
	.battery_to_converter(btc), .engine_run(er), .engine_start_addr(esa), .chop_polarity(pol),
	.test_clock_pin(tp), .timer_zero_input(tmr_zero), .timer_one_input(tmr_one), .high_priority_irq(hi),
	.low_priority_irq(lo));
initial begin
	clk = 0;
	forever #12.5 clk = ~clk;
end
task results; begin
	if (mismatches == 0 && compares > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
end endtask
task chk(input [63:0] nm, input [15:0] e, input [15:0] g); begin
	compares = compares + 1;
	if (e !== g) begin
		mismatches = mismatches + 1;
		$display("ERROR %0s expected %h seen %h", nm, e, g);
	end
end endtask
task wr(input [15:0] a, input [7:0] d); begin
	@(negedge clk) addr = a;
	wr_data = d;
	wr_en = 1;
	@(negedge clk) wr_en = 0;
end endtask
task rd(input [15:0] a, input [7:0] e); begin
	@(negedge clk) addr = a;
	rd_en = 1;
	@(negedge clk) rd_en = 0;
	chk("rd_data", e, rd_data);
end endtask
// Counts irq pulses and chop flips seen at falling edges
task watch(input integer c);
	reg p;
	begin
	p = pol;
	repeat (c) begin
		@(negedge clk);
		nh = nh + hi;
		nl = nl + lo;
		nc = nc + (pol !== p);
		p = pol;
	end
end endtask
initial begin
	#1_000_000;
	mismatches = mismatches + 1;
	results;
end
initial begin
	rst = 1; wake = 0; wr_en = 0; rd_en = 0; addr = 0; wr_data = 0; cmp = 0; fck = 0; seg = 1;
	push = 0;
	opt = 0;
	dio = 0;
	mismatches = 0;
	compares = 0;
	repeat (3) @(negedge clk);
	rst = 0;
	chk("esa", 16'h7c00, esa);
	for (i = 0; i < 5; i = i + 1) rd(16'h2009 + i, 8'h00);
	rd(16'h20a8, 8'h1f);
	rd(16'h2002, 8'h00);
	rd(16'h2004, 8'h00);
	wr(16'h2009, 8'hff);
	rd(16'h2009, 8'h77);
	wr(16'h200a, 8'hff);
	rd(16'h200a, 8'h07);
	wr(16'h2001, 8'hff);
	rd(16'h2001, 8'h00);
	wr(16'h2003, 8'hff);
	rd(16'h2003, 8'h00);
	cmp = 1;
	repeat (4) @(negedge clk);
	rd(16'h2003, 8'h01);
	wr(16'h20a8, 8'h05);
	chk("esa", 16'h1400, esa);
	wr(16'h2000, 8'h10);
	chk("run", 1, er);
	wr(16'h2005, 8'h08);
	chk("conv", 1, cp);
	wr(16'h2020, 8'h40);
	rd(16'h2020, 8'h40);
	chk("bl", 1, bl);
	for (i = 0; i < 2; i = i + 1) begin
		repeat (16) @(negedge clk);
		chk("btc", alt, btc);
	end
	wake = 1;
	@(negedge clk) wake = 0;
	chk("esa", 16'h7c00, esa);
	chk("conv", 0, cp + er);
	chk("bat", 1, bl);
	for (i = 0; i < 4; i = i + 1) begin
		wr(16'h2004, i << 4);
		for (j = 0; j < 2; j = j + 1) begin
			@(negedge clk) seg = j;
			fck = !j;
			#1 chk("tclk", i == 0 ? j : i == 1 ? !j : 0, tp);
		end
	end
	wr(16'h2009, 8'h22);
	wr(16'h200a, 8'h02);
	for (i = 0; i < 4; i = i + 1) begin
		{dio[0], opt, push} = (i < 3) ? 3'h1 << i : 3'h0;
		repeat (4) @(negedge clk);
		chk("timer0", i < 3, {tmr_one, tmr_zero});
	end
	wr(16'h200a, 8'h00);
	wr(16'h2009, 8'h03);
	push = 1;
	repeat (4) @(negedge clk);
	chk("timer1", 2, {tmr_one, tmr_zero});
	wr(16'h2009, 8'h01);
	@(negedge clk) chk("rsvd", 0, {tmr_one, tmr_zero});
	for (i = 4; i < 8; i = i + 1) begin
		push = 0;
		wr(16'h2009, i);
		repeat (4) @(negedge clk);
		nh = 0;
		nl = 0;
		push = 1;
		watch(8);
		push = 0;
		watch(8);
		chk("irq", {i == 4 || i == 6, i == 5 || i == 7}, {nh[0], nl[0]});
	end
	for (i = 1; i < 3; i = i + 1) begin
		wr(16'h2002, i << 4);
		repeat (40) @(negedge clk);
		chk("chop", i - 1, pol);
	end
	wr(16'h2002, 8'h30);
	repeat (20) @(negedge clk);
	nc = 0;
	watch(128);
	chk("flips", 8, nc);
	wr(16'h2002, 8'h00);
	repeat (20) @(negedge clk);
	nc = 0;
	watch(128);
	chk("flips", 6, nc);
	results;
end
endmodule // tb
